// ### core/psc_pkg.sv
/*
  constants, register map and types for position scaling and commutation.
  assumes one 100 MHz clock and a byte-addressed 32-bit register port.
*/
package psc_pkg;

  // register byte offsets
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STATUS    = 8'h04;
  localparam logic [7:0] A_LINES     = 8'h08;
  localparam logic [7:0] A_FEED      = 8'h0c;
  localparam logic [7:0] A_GEAR      = 8'h10;
  localparam logic [7:0] A_FACTOR    = 8'h14;
  localparam logic [7:0] A_INDEX_POS = 8'h18;
  localparam logic [7:0] A_TGT_POS   = 8'h1c;
  localparam logic [7:0] A_TGT_VEL   = 8'h20;
  localparam logic [7:0] A_TGT_ACC   = 8'h24;
  localparam logic [7:0] A_ACT_INC   = 8'h28;
  localparam logic [7:0] A_ANGLE     = 8'h2c;
  localparam logic [7:0] A_HALL_BASE = 8'h40;
  localparam logic [7:0] A_HALL_LAST = 8'h54;

  // field positions
  localparam int CTRL_EMUL   = 0;
  localparam int CTRL_DERIVE = 1;
  localparam int CTRL_REARM  = 2;
  localparam int ST_NOIDX    = 2;

  // scaling
  localparam int          EDGES_PER_LINE = 4;
  localparam int          FRAC_BITS      = 16;
  localparam logic [31:0] FACTOR_ONE     = 32'h0001_0000;
  localparam logic [5:0]  DIV_LAST       = 6'h3f;
  localparam int          HALL_N         = 6;

  // reset values
  localparam logic [31:0] LINES_RST  = 32'h0000_03e8;
  localparam logic [31:0] FEED_RST   = 32'h0000_0fa0;
  localparam logic [31:0] GEAR_RST   = 32'h0001_0001;
  localparam logic [31:0] FACTOR_RST = FACTOR_ONE;

  typedef enum logic [1:0] {
    CM_HALL    = 2'b01,
    CM_ALIGNED = 2'b10
  } comm_state_t;

endpackage

// ### core/hall_pos_mem.sv
/*
  six-entry table of hall sector rotor positions, one write port and two
  registered read ports. assumes synchronous active-high reset.
*/
module hall_pos_mem
  import psc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [2:0]  a_idx,
  output logic      [31:0] a_data,
  input  wire logic [2:0]  b_idx,
  output logic      [31:0] b_data
);

  typedef struct packed {
    logic [HALL_N-1:0][31:0] mem;
    logic [31:0]             a;
    logic [31:0]             b;
  } mem_state_t;

  mem_state_t r;
  mem_state_t next_r;

  always_comb begin
    next_r = r;
    if (wr_en && wr_idx < 3'(HALL_N)) begin
      next_r.mem[wr_idx] = wr_data;
    end
    next_r.a = (a_idx < 3'(HALL_N)) ? r.mem[a_idx] : 32'h0000_0000;
    next_r.b = (b_idx < 3'(HALL_N)) ? r.mem[b_idx] : 32'h0000_0000;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign a_data = r.a;
  assign b_data = r.b;

endmodule

// ### core/position_scaling_commutation.sv
/*
  encoder increment counter, user-unit scaling and hall/index commutation.
  assumes encoder, index and hall inputs already synchronous to core_clk.
*/
// How it works
// - four increments per encoder line
// - one position factor for every conversion
// - velocity and acceleration scaled by same factor
// - factor may be written directly
// - equal feed and resolution gives factor one when both gear halves are equal
// - three hall inputs decode into six sectors
// - commutate on hall table until first index
// - first index loads index position into angle
// - emulated index when emulation enabled
module position_scaling_commutation
  import psc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_index,
  input  wire logic [2:0]  hall,
  output logic      [31:0] actual_inc,
  output logic      [31:0] pos_demand,
  output logic      [31:0] vel_demand,
  output logic      [31:0] acc_demand,
  output logic      [31:0] comm_angle,
  output logic             comm_aligned
);

  typedef struct packed {
    comm_state_t cm;
    logic        emul;
    logic [31:0] lines;
    logic [31:0] feed;
    logic [31:0] gear;
    logic [31:0] factor;
    logic [31:0] index_pos;
    logic [31:0] tgt_pos;
    logic [31:0] tgt_vel;
    logic [31:0] tgt_acc;
    logic [1:0]  q_prev;
    logic        idx_prev;
    logic [2:0]  sector;
    logic        sect_ok;
    logic [31:0] act;
    logic [31:0] angle;
    logic [31:0] travel;
    logic        noidx;
    logic        busy;
    logic [5:0]  cnt;
    logic [63:0] quo;
    logic [48:0] rem;
    logic [47:0] den;
    logic [31:0] rd_data;
    logic        rd_hall;
    logic [31:0] pos_d;
    logic [31:0] vel_d;
    logic [31:0] acc_d;
  } state_t;

  state_t r;
  state_t next_r;

  logic [31:0] hall_a;
  logic [31:0] hall_b;
  logic [1:0]  q_now;
  logic [1:0]  q_diff;
  logic        fwd;
  logic        rev;
  logic [31:0] res;
  logic [47:0] num_w;
  logic [47:0] den_w;
  logic        hall_ok;
  logic [2:0]  hall_sect;
  logic        sect_chg;
  logic        real_idx;
  logic        emu_idx;
  logic        hall_wr;
  logic        hall_rd;

  // fixed-point multiply; product truncates toward minus infinity
  function automatic logic [31:0] scale(input logic [31:0] v, input logic [31:0] f);
    logic signed [64:0] p;
    p = $signed(v) * $signed({1'b0, f});
    return p[FRAC_BITS+31:FRAC_BITS];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  assign q_now     = {enc_a, enc_a ^ enc_b};
  assign q_diff    = q_now - r.q_prev;
  assign fwd       = (q_diff == 2'h1);
  assign rev       = (q_diff == 2'h3);
  assign res       = 32'(r.lines * EDGES_PER_LINE);
  assign num_w     = 48'(res) * 48'(r.gear[15:0]);
  assign den_w     = 48'(r.feed) * 48'(r.gear[31:16]);
  assign hall_ok   = (hall != 3'h0) && (hall != 3'h7);
  assign hall_sect = hall - 3'h1;
  assign sect_chg  = hall_ok && r.sect_ok && (hall_sect != r.sector);
  assign real_idx  = enc_index && !r.idx_prev && !r.emul;
  assign emu_idx   = r.emul && sect_chg;
  assign hall_wr   = wr_en && addr >= A_HALL_BASE && addr <= A_HALL_LAST && addr[1:0] == 2'h0;
  assign hall_rd   = rd_en && addr >= A_HALL_BASE && addr <= A_HALL_LAST && addr[1:0] == 2'h0;

  hall_pos_mem u_hall (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (hall_wr),
    .wr_idx   (addr[4:2]),
    .wr_data  (wr_data),
    .a_idx    (r.sector),
    .a_data   (hall_a),
    .b_idx    (addr[4:2]),
    .b_data   (hall_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.q_prev   = q_now;
    next_r.idx_prev = enc_index;
    if (fwd) begin
      next_r.act = r.act + 32'h1;
    end else if (rev) begin
      next_r.act = r.act - 32'h1;
    end
    if (hall_ok) begin
      next_r.sector  = hall_sect;
      next_r.sect_ok = 1'b1;
    end
    // a stray hall code 000/111 keeps the last good sector
    unique case (r.cm)
      CM_HALL: begin
        next_r.angle = hall_a;
        if (fwd || rev) begin
          next_r.travel = r.travel + 32'h1;
        end
        if (real_idx || emu_idx) begin
          next_r.cm    = CM_ALIGNED;
          next_r.angle = r.index_pos;
        end
      end
      CM_ALIGNED: begin
        if (real_idx) begin
          next_r.angle = r.index_pos;
        end else if (fwd) begin
          next_r.angle = (r.angle + 32'h1 >= res) ? 32'h0 : r.angle + 32'h1;
        end else if (rev) begin
          next_r.angle = (r.angle == 32'h0) ? res - 32'h1 : r.angle - 32'h1;
        end
      end
    endcase
    // user units to increments, one factor for all three
    next_r.pos_d = scale(r.tgt_pos, r.factor);
    next_r.vel_d = scale(r.tgt_vel, r.factor);
    next_r.acc_d = scale(r.tgt_acc, r.factor);
    // restoring divider, 64 steps; slow but tiny and runs only on demand
    if (r.busy) begin
      next_r.rem = {r.rem[47:0], r.quo[63]};
      next_r.quo = {r.quo[62:0], 1'b0};
      if (next_r.rem >= {1'b0, r.den}) begin
        next_r.rem    = next_r.rem - {1'b0, r.den};
        next_r.quo[0] = 1'b1;
      end
      next_r.cnt = r.cnt + 6'h1;
      if (r.cnt == DIV_LAST) begin
        next_r.busy   = 1'b0;
        next_r.factor = (|next_r.quo[63:32]) ? 32'hffff_ffff : next_r.quo[31:0];
      end
    end
    if (wr_en) begin
      unique case (addr)
        A_CTRL: begin
          next_r.emul = wr_data[CTRL_EMUL];
          if (wr_data[CTRL_DERIVE] && !r.busy && den_w != 48'h0) begin
            next_r.busy = 1'b1;
            next_r.cnt  = 6'h0;
            next_r.quo  = {num_w, 16'h0000};
            next_r.rem  = '0;
            next_r.den  = den_w;
          end
          if (wr_data[CTRL_REARM]) begin
            next_r.cm     = CM_HALL;
            next_r.travel = 32'h0;
          end
        end
        A_STATUS:    if (wr_data[ST_NOIDX]) next_r.noidx = 1'b0;
        A_LINES:     next_r.lines = wr_data;
        A_FEED:      next_r.feed = wr_data;
        A_GEAR:      next_r.gear = wr_data;
        A_FACTOR:    if (!r.busy) next_r.factor = wr_data;
        A_INDEX_POS: next_r.index_pos = wr_data;
        A_TGT_POS:   next_r.tgt_pos = wr_data;
        A_TGT_VEL:   next_r.tgt_vel = wr_data;
        A_TGT_ACC:   next_r.tgt_acc = wr_data;
        default:     ;
      endcase
    end
    // set after clear so a same-cycle event is kept
    if (r.cm == CM_HALL && res != 32'h0 && r.travel >= res) begin
      next_r.noidx = 1'b1;
    end
    next_r.rd_hall = hall_rd;
    next_r.rd_data = 32'h0;
    if (rd_en) begin
      unique case (addr)
        A_CTRL:      next_r.rd_data = {31'h0, r.emul};
        A_STATUS:    next_r.rd_data = {25'h0, r.sector, 1'b0, r.noidx, r.busy,
                                       r.cm == CM_ALIGNED};
        A_LINES:     next_r.rd_data = r.lines;
        A_FEED:      next_r.rd_data = r.feed;
        A_GEAR:      next_r.rd_data = r.gear;
        A_FACTOR:    next_r.rd_data = r.factor;
        A_INDEX_POS: next_r.rd_data = r.index_pos;
        A_TGT_POS:   next_r.rd_data = r.tgt_pos;
        A_TGT_VEL:   next_r.rd_data = r.tgt_vel;
        A_TGT_ACC:   next_r.rd_data = r.tgt_acc;
        A_ACT_INC:   next_r.rd_data = r.act;
        A_ANGLE:     next_r.rd_data = r.angle;
        default:     next_r.rd_data = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r        <= '0;
      r.cm     <= CM_HALL;
      r.lines  <= LINES_RST;
      r.feed   <= FEED_RST;
      r.gear   <= GEAR_RST;
      r.factor <= FACTOR_RST;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data      = r.rd_hall ? hall_b : r.rd_data;
  assign actual_inc   = r.act;
  assign pos_demand   = r.pos_d;
  assign vel_demand   = r.vel_d;
  assign acc_demand   = r.acc_d;
  assign comm_angle   = r.angle;
  assign comm_aligned = r.cm[1];

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_four_edges;
    fwd [*4] |=> actual_inc == $past(actual_inc, 4) + 32'h4;
  endproperty
  a_four_edges: assert property (p_four_edges) else $error("four edges not four counts");

  property p_reverse;
    rev |=> actual_inc == $past(actual_inc) - 32'h1;
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse step not counted down");

  property p_pos_unity;
    r.factor == FACTOR_ONE |=> pos_demand == $past(r.tgt_pos);
  endproperty
  a_pos_unity: assert property (p_pos_unity) else $error("unity factor changed position");

  property p_vel_acc_double;
    r.factor == 32'h0002_0000 |=>
      vel_demand == 32'($past(r.tgt_vel) << 1) && acc_demand == 32'($past(r.tgt_acc) << 1);
  endproperty
  a_vel_acc_double: assert property (p_vel_acc_double) else $error("vel/acc scale wrong");

  property p_factor_write;
    wr_en && addr == A_FACTOR && !r.busy |=> r.factor == $past(wr_data);
  endproperty
  a_factor_write: assert property (p_factor_write) else $error("factor write lost");

  property p_unity_derive;
    wr_en && addr == A_CTRL && wr_data[CTRL_DERIVE] && !r.busy && den_w != 48'h0
      && num_w == den_w |-> ##65 (!r.busy && r.factor == FACTOR_ONE);
  endproperty
  a_unity_derive: assert property (p_unity_derive) else $error("derived factor not one");

  property p_sector;
    hall_ok |=> r.sector == $past(hall) - 3'h1 && r.sect_ok;
  endproperty
  a_sector: assert property (p_sector) else $error("hall sector decode wrong");

  property p_no_index;
    r.cm == CM_HALL && res != 32'h0 && r.travel >= res |=> r.noidx;
  endproperty
  a_no_index: assert property (p_no_index) else $error("missing index not flagged");

  property p_index_load;
    r.cm == CM_HALL && real_idx && !(wr_en && addr == A_CTRL && wr_data[CTRL_REARM])
      |=> comm_aligned && comm_angle == $past(r.index_pos);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index did not align");

  property p_emul;
    r.cm == CM_HALL && emu_idx && !(wr_en && addr == A_CTRL) |=> comm_aligned;
  endproperty
  a_emul: assert property (p_emul) else $error("emulated index ignored");

  c_aligned:  cover property (r.cm == CM_HALL ##1 r.cm == CM_ALIGNED);
  c_noidx:    cover property (!r.noidx ##1 r.noidx);
  c_derive:   cover property (r.busy ##1 !r.busy);
  c_emulated: cover property (emu_idx && r.cm == CM_HALL);

endmodule

// ### testbench/motor_model.sv
/*
  behavioural motor far side: quadrature encoder, index pulse, hall sensors.
  assumes the testbench calls its tasks and that core_clk runs freely.
*/
module motor_model (
  input  wire logic       core_clk,
  output logic            enc_a,
  output logic            enc_b,
  output logic            enc_index,
  output logic      [2:0] hall
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase;

  ////////////////////////////////////////////////////////////////////////////
  // gray order of {a,b}: 00, 01, 11, 10 going forward
  assign enc_a = phase[1];
  assign enc_b = phase[1] ^ phase[0];

  initial begin
    phase     = 2'h0;
    enc_index = 1'b0;
    hall      = 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // gap sets the pace: 1 for a fast shaft, larger for a slow one
  task automatic step(input int n, input bit fwd, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge core_clk);
      phase <= fwd ? phase + 2'h1 : phase - 2'h1;
    end
  endtask

  // one-cycle index mark, a real encoder gives no longer one at low speed
  task automatic index_mark();
    @(posedge core_clk);
    enc_index <= 1'b1;
    @(posedge core_clk);
    enc_index <= 1'b0;
  endtask

  task automatic set_hall(input logic [2:0] code);
    @(posedge core_clk);
    hall <= code;
  endtask
endmodule

// ### testbench/testbench.sv
/*
  self-checking bench: register port tasks, scaling, encoder and commutation.
  assumes the design's own assertions and the motor_model partner.
*/
module testbench
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        enc_a;
  logic        enc_b;
  logic        enc_index;
  logic [2:0]  hall;
  logic [31:0] actual_inc;
  logic [31:0] pos_demand;
  logic [31:0] vel_demand;
  logic [31:0] acc_demand;
  logic [31:0] comm_angle;
  logic        comm_aligned;
  int          mismatches;
  int          n_compared;
  logic [31:0] d;
  logic [31:0] fac;

  position_scaling_commutation i_position_scaling_commutation (
    .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .enc_a(enc_a),
    .enc_b(enc_b), .enc_index(enc_index), .hall(hall), .actual_inc(actual_inc),
    .pos_demand(pos_demand), .vel_demand(vel_demand), .acc_demand(acc_demand),
    .comm_angle(comm_angle), .comm_aligned(comm_aligned));

  motor_model i_motor_model (
    .core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .hall(hall));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // signed user value times Q16.16 factor, worked out independently
  function automatic logic [31:0] scale(input logic [31:0] u, input logic [31:0] f);
    longint p;
    p = (longint'($signed(u)) * longint'(f)) >>> 16;
    return p[31:0];
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    addr       = 8'h00;
    wr_data    = 32'h0000_0000;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(A_LINES, LINES_RST);
    rdchk(A_FEED, FEED_RST);
    rdchk(A_GEAR, GEAR_RST);
    rdchk(A_FACTOR, FACTOR_RST);
    rdchk(8'hfc, 32'h0000_0000);
    // direct factor 2.5 scales position, velocity and acceleration alike
    fac = 32'h0002_8000;
    wr(A_FACTOR, fac);
    wr(A_TGT_POS, 32'h0000_0064);
    wr(A_TGT_VEL, 32'h0000_0007);
    wr(A_TGT_ACC, 32'hffff_fffd);
    settle(2);
    check(pos_demand, scale(32'h0000_0064, fac));
    check(vel_demand, scale(32'h0000_0007, fac));
    check(acc_demand, scale(32'hffff_fffd, fac));
    // factor two doubles all three demands exactly
    wr(A_FACTOR, 32'h0002_0000);
    settle(2);
    check(pos_demand, 32'h0000_00c8);
    check(vel_demand, 32'h0000_000e);
    check(acc_demand, 32'hffff_fffa);
    // derived factor: equal feed gives exactly one, double feed gives one half
    for (int k = 1; k <= 2; k++) begin
      wr(A_FEED, 32'(4000 * k));
      wr(A_CTRL, 32'h0000_0002);
      settle(70);
      fac = 32'((longint'(4 * 1000) <<< 16) / (4000 * k));
      rdchk(A_FACTOR, fac);
      wr(A_TGT_POS, 32'h0000_0123);
      settle(2);
      check(pos_demand, scale(32'h0000_0123, fac));
    end
    for (int i = 0; i < HALL_N; i++)
      wr(8'(A_HALL_BASE + 4 * i), 32'((i + 1) * 256));
    wr(A_INDEX_POS, 32'h0000_0055);
    rdchk(8'(A_HALL_BASE + 8), 32'h0000_0300);
    // one encoder line forward, then a line and a half back at a slow pace
    i_motor_model.step(4, 1'b1, 1);
    settle(3);
    check(actual_inc, 32'h0000_0004);
    i_motor_model.step(6, 1'b0, 5);
    settle(3);
    check(actual_inc, 32'hffff_fffe);
    rdchk(A_ACT_INC, 32'hffff_fffe);
    // every valid hall code selects its own sector and table entry
    for (int c = 1; c <= 6; c++) begin
      i_motor_model.set_hall(3'(c));
      settle(4);
      check(comm_angle, 32'(c * 256));
      check({31'h0, comm_aligned}, 32'h0000_0000);
      rd(A_STATUS, d);
      check({29'h0, d[6:4]}, 32'(c - 1));
    end
    i_motor_model.index_mark();
    settle(2);
    check({31'h0, comm_aligned}, 32'h0000_0001);
    check(comm_angle, 32'h0000_0055);
    i_motor_model.step(3, 1'b1, 1);
    settle(3);
    check(comm_angle, 32'h0000_0058);
    // emulation on: real index ignored, first sector change aligns instead
    wr(A_CTRL, 32'h0000_0005);
    settle(3);
    check({31'h0, comm_aligned}, 32'h0000_0000);
    rdchk(A_CTRL, 32'h0000_0001);
    i_motor_model.index_mark();
    settle(3);
    check({31'h0, comm_aligned}, 32'h0000_0000);
    i_motor_model.set_hall(3'h1);
    settle(4);
    check({31'h0, comm_aligned}, 32'h0000_0001);
    check(comm_angle, 32'h0000_0055);
    // stray hall code keeps the sector; a revolution without index is flagged
    i_motor_model.set_hall(3'h7);
    settle(4);
    rd(A_STATUS, d);
    check({29'h0, d[6:4]}, 32'h0000_0000);
    wr(A_LINES, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0004);
    i_motor_model.step(8, 1'b1, 1);
    settle(3);
    rdchk(A_STATUS, 32'h0000_0004);
    wr(A_CTRL, 32'h0000_0004);
    wr(A_STATUS, 32'h0000_0004);
    rdchk(A_STATUS, 32'h0000_0000);
    finish_test();
  end
endmodule
